// >>> core/dram_refresh_controller.sv
// dynamic RAM refresh controller with its control register
// Functional notes
// - refresh_on clear inserts no refresh; set inserts them at the interval.
// - refresh cycle is two clocks, three with refresh_extra_wait set.
// - interval select 00/01/10/11 gives 10/20/40/80 clock states.
// - reset sets refresh_on and extra wait, clears interval select.
// - no refresh during reset, bus grant, sleep or wait states.
// - timer runs during bus grant; next refresh follows the timer.
// - request during sleep is latched, newer replaces older, none issued.
// - latched request issues at end of first machine cycle after sleep.
// - after that cycle, next refresh timing comes from timer only.
// - refresh address advances only on a performed refresh cycle.
// - each refresh cycle address is previous refresh address plus one.
`timescale 1ns/1ns
`include "refresh_cfg.svh"

module dram_refresh_controller
    import refresh_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    // internal I/O access
    input wire logic [7:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    input wire logic IO_WR,
    input wire logic IO_RD,
    output logic [7:0] IO_RDATA,
    // processor bus status
    input wire logic MCYCLE_END,
    input wire logic BUS_GRANTED,
    input wire logic SLEEP,
    input wire logic WAIT_STATE,
    // refresh bus cycle
    output logic REF_BUSY,
    output logic REF_STROBE_N,
    output logic REF_WAIT,
    output logic [7:0] REF_ADDR
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    rst_sync_t rs;
    logic rst_n;

    // only the second flop feeds the design
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rs <= '0;
        end else begin
            rs.rst_meta <= 1'b1;
            rs.rst_sync <= rs.rst_meta;
        end
    end

    assign rst_n = rs.rst_sync;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ctrl_state_t cur;
    ctrl_state_t next_cur;
    logic tick;
    logic reg_hit;
    logic [7:0] reg_value;
    logic may_insert;
    logic start_cycle;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] rst_sel = `RC_RST_INTERVAL_SEL;

    // ----------------------------------------------------------------
    // interval timer
    // ----------------------------------------------------------------
    // keeps counting through bus grant and sleep
    refresh_timer u_timer (
        .clk(CLK),
        .rst_n(rst_n),
        .run(cur.refresh_on),
        .sel({cur.interval_select_hi, cur.interval_select_lo}),
        .expire(tick)
    );

    // ----------------------------------------------------------------
    // register view
    // ----------------------------------------------------------------
    assign reg_hit = (IO_ADDR == `RC_ADDR_REFRESH_CONTROL);

    always_comb begin
        reg_value = 8'h00;
        reg_value[`RC_BIT_REFRESH_ON] = cur.refresh_on;
        reg_value[`RC_BIT_EXTRA_WAIT] = cur.refresh_extra_wait;
        reg_value[`RC_BIT_SEL_HI] = cur.interval_select_hi;
        reg_value[`RC_BIT_SEL_LO] = cur.interval_select_lo;
    end

    // ----------------------------------------------------------------
    // insertion gate
    // ----------------------------------------------------------------
    // a refresh cycle slots in only at a machine cycle boundary
    assign may_insert = MCYCLE_END
        && !BUS_GRANTED
        && !SLEEP
        && !WAIT_STATE;

    // ----------------------------------------------------------------
    // cycle start
    // ----------------------------------------------------------------
    // one term shared by the latch clear and the sequencer
    assign start_cycle = cur.refresh_on && cur.pending && may_insert
        && (cur.state == RS_IDLE);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_cur = cur;

        // register write
        if (IO_WR && reg_hit) begin
            next_cur.refresh_on = IO_WDATA[`RC_BIT_REFRESH_ON];
            next_cur.refresh_extra_wait = IO_WDATA[`RC_BIT_EXTRA_WAIT];
            next_cur.interval_select_hi = IO_WDATA[`RC_BIT_SEL_HI];
            next_cur.interval_select_lo = IO_WDATA[`RC_BIT_SEL_LO];
        end

        // register read, unmapped reads return zero
        if (IO_RD && reg_hit) begin
            next_cur.rdata = reg_value;
        end else begin
            next_cur.rdata = 8'h00;
        end

        // request latch
        if (!cur.refresh_on) begin
            next_cur.pending = 1'b0;
        end else if (BUS_GRANTED) begin
            // requests missed under grant are dropped
            next_cur.pending = 1'b0;
        end else if (tick) begin
            // a newer request overwrites the held one
            next_cur.pending = 1'b1;
        end else if (start_cycle) begin
            next_cur.pending = 1'b0;
        end

        // refresh bus cycle sequencer
        case (cur.state)
            RS_IDLE: begin
                next_cur.busy = 1'b0;
                next_cur.strobe_n = 1'b1;
                next_cur.wait_state = 1'b0;
                if (start_cycle) begin
                    next_cur.state = RS_T1;
                    next_cur.busy = 1'b1;
                    next_cur.strobe_n = 1'b0;
                end
            end
            RS_T1: begin
                if (cur.refresh_extra_wait) begin
                    next_cur.state = RS_TW;
                    next_cur.wait_state = 1'b1;
                end else begin
                    next_cur.state = RS_T2;
                end
            end
            RS_TW: begin
                next_cur.state = RS_T2;
                next_cur.wait_state = 1'b0;
            end
            RS_T2: begin
                next_cur.state = RS_IDLE;
                next_cur.busy = 1'b0;
                next_cur.strobe_n = 1'b1;
                // advance only for a cycle actually run
                next_cur.addr = cur.addr + 8'h01;
            end
            default: begin
                next_cur.state = RS_IDLE;
                next_cur.busy = 1'b0;
                next_cur.strobe_n = 1'b1;
                next_cur.wait_state = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cur.refresh_on <= `RC_RST_REFRESH_ON;
            cur.refresh_extra_wait <= `RC_RST_EXTRA_WAIT;
            cur.interval_select_hi <= rst_sel[1];
            cur.interval_select_lo <= rst_sel[0];
            cur.pending <= 1'b0;
            cur.state <= RS_IDLE;
            cur.addr <= `RC_RST_ADDR;
            cur.busy <= 1'b0;
            cur.strobe_n <= 1'b1;
            cur.wait_state <= 1'b0;
            cur.rdata <= 8'h00;
        end else begin
            cur <= next_cur;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign IO_RDATA = cur.rdata;
    assign REF_BUSY = cur.busy;
    assign REF_STROBE_N = cur.strobe_n;
    assign REF_WAIT = cur.wait_state;
    assign REF_ADDR = cur.addr;

endmodule

// >>> core/refresh_cfg.svh
// offsets, field positions, reset values and interval counts
`ifndef REFRESH_CFG_SVH
`define REFRESH_CFG_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define RC_ADDR_REFRESH_CONTROL 8'h36

// ----------------------------------------------------------------
// refresh_control fields
// ----------------------------------------------------------------
`define RC_BIT_REFRESH_ON 7
`define RC_BIT_EXTRA_WAIT 6
`define RC_BIT_SEL_HI 1
`define RC_BIT_SEL_LO 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RC_RST_REFRESH_ON 1'b1
`define RC_RST_EXTRA_WAIT 1'b1
`define RC_RST_INTERVAL_SEL 2'h0
`define RC_RST_ADDR 8'h00

// ----------------------------------------------------------------
// interval counts in clock states
// ----------------------------------------------------------------
`define RC_INTERVAL_00 7'h0A
`define RC_INTERVAL_01 7'h14
`define RC_INTERVAL_10 7'h28
`define RC_INTERVAL_11 7'h50

`endif

// >>> core/refresh_pkg.sv
// types shared by the refresh controller and its interval timer
package refresh_pkg;

    typedef enum logic [1:0] {
        RS_IDLE,
        RS_T1,
        RS_TW,
        RS_T2
    } ref_state_t;

    typedef struct packed {
        logic [6:0] count;
        logic expire;
    } timer_state_t;

    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
    } rst_sync_t;

    typedef struct packed {
        logic refresh_on;
        logic refresh_extra_wait;
        logic interval_select_hi;
        logic interval_select_lo;
        logic pending;
        ref_state_t state;
        logic [7:0] addr;
        logic busy;
        logic strobe_n;
        logic wait_state;
        logic [7:0] rdata;
    } ctrl_state_t;

endpackage

// >>> core/refresh_timer.sv
// free-running refresh interval timer, one pulse per expiry
`timescale 1ns/1ns
`include "refresh_cfg.svh"

module refresh_timer
    import refresh_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [1:0] sel,
    output logic expire
);

    timer_state_t cur;
    timer_state_t nxt;
    logic [6:0] period;

    // ----------------------------------------------------------------
    // interval select
    // ----------------------------------------------------------------
    always_comb begin
        case (sel)
            2'h0: period = `RC_INTERVAL_00;
            2'h1: period = `RC_INTERVAL_01;
            2'h2: period = `RC_INTERVAL_10;
            default: period = `RC_INTERVAL_11;
        endcase
    end

    // ----------------------------------------------------------------
    // count down, reload on expiry
    // ----------------------------------------------------------------
    always_comb begin
        nxt = cur;
        nxt.expire = 1'b0;
        if (!run) begin
            nxt.count = 7'h00;
        end else if (cur.count == 7'h00) begin
            // first expiry one full period after enable
            nxt.count = period - 7'h01;
        end else if (cur.count == 7'h01) begin
            nxt.count = period;
            nxt.expire = 1'b1;
        end else begin
            nxt.count = cur.count - 7'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign expire = cur.expire;

endmodule

// >>> test/refresh_monitor.sv
// assertion checker bound to the refresh controller ports
`timescale 1ns/1ns
`include "refresh_cfg.svh"
module refresh_monitor (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [7:0] IO_ADDR,
    input wire logic IO_RD,
    input wire logic [7:0] IO_RDATA,
    input wire logic MCYCLE_END,
    input wire logic BUS_GRANTED,
    input wire logic SLEEP,
    input wire logic WAIT_STATE,
    input wire logic REF_BUSY,
    input wire logic REF_STROBE_N,
    input wire logic REF_WAIT,
    input wire logic [7:0] REF_ADDR
);
default clocking @(posedge CLK);
endclocking
default disable iff (!RSTN);
a_cycle_shape: assert property ($rose(REF_BUSY) |=>
    (REF_WAIT ##1 (REF_BUSY && !REF_WAIT) ##1 !REF_BUSY)
    or ((REF_BUSY && !REF_WAIT) ##1 !REF_BUSY))
    else $error("refresh cycle shape");
a_busy_max: assert property (REF_BUSY [*3] |=> !REF_BUSY)
    else $error("refresh cycle too long");
a_strobe_busy: assert property (REF_STROBE_N == !REF_BUSY)
    else $error("strobe and busy disagree");
a_wait_inside: assert property (REF_WAIT |-> REF_BUSY)
    else $error("wait clock outside cycle");
a_start_cause: assert property ($rose(REF_BUSY) |-> $past(MCYCLE_END)
    && !$past(BUS_GRANTED) && !$past(SLEEP) && !$past(WAIT_STATE))
    else $error("refresh started while blocked");
a_addr_step: assert property ($fell(REF_BUSY) |->
    REF_ADDR == 8'($past(REF_ADDR) + 8'h01)) else $error("address step");
a_addr_hold: assert property (!$fell(REF_BUSY) |-> $stable(REF_ADDR))
    else $error("address moved without refresh");
a_rdata_idle: assert property (!($past(IO_RD) &&
    $past(IO_ADDR) == `RC_ADDR_REFRESH_CONTROL) |-> IO_RDATA == 8'h00)
    else $error("read data without read");
c_long: cover property ($rose(REF_BUSY) ##1 REF_WAIT);
c_short: cover property ($rose(REF_BUSY) ##1 !REF_WAIT ##1 !REF_BUSY);
c_sleep: cover property ($fell(SLEEP) ##[1:8] $rose(REF_BUSY));
endmodule
bind dram_refresh_controller refresh_monitor mon (.CLK(CLK), .RSTN(RSTN),
    .IO_ADDR(IO_ADDR), .IO_RD(IO_RD), .IO_RDATA(IO_RDATA),
    .MCYCLE_END(MCYCLE_END), .BUS_GRANTED(BUS_GRANTED), .SLEEP(SLEEP),
    .WAIT_STATE(WAIT_STATE), .REF_BUSY(REF_BUSY),
    .REF_STROBE_N(REF_STROBE_N), .REF_WAIT(REF_WAIT), .REF_ADDR(REF_ADDR));

// >>> test/dram_model.sv
// external dynamic RAM that records each refreshed row
`timescale 1ns/1ns
module dram_model (
    input wire logic strobe_n,
    input wire logic [7:0] row,
    output int rows_done,
    output int row_errs
);
logic [7:0] last_row = 8'h00;
initial rows_done = 0;
initial row_errs = 0;
always @(negedge strobe_n) begin
    if (rows_done > 0 && row !== 8'(last_row + 8'h01)) begin
        row_errs++;
    end
    last_row = row;
    rows_done++;
end
endmodule

// >>> test/dram_refresh_controller_tb.sv
// self-checking bench for the refresh controller
`timescale 1ns/1ns
`include "refresh_cfg.svh"
module dram_refresh_controller_tb;
logic clk = 1'b0;
logic rstn = 1'b0;
logic io_wr = 1'b0;
logic io_rd = 1'b0;
logic mcyc = 1'b1;
logic grant = 1'b0;
logic sleep = 1'b0;
logic wait_st = 1'b0;
logic [7:0] io_addr = 8'h00;
logic [7:0] io_wdata = 8'h00;
logic [7:0] io_rdata, ref_addr;
logic ref_busy, ref_strobe_n, ref_wait, prev_busy;
int mismatches = 0;
int num_checks = 0;
int cyc = 0;
int rows_done, row_errs;
dram_refresh_controller dut (.CLK(clk), .RSTN(rstn), .IO_ADDR(io_addr),
    .IO_WDATA(io_wdata), .IO_WR(io_wr), .IO_RD(io_rd), .IO_RDATA(io_rdata),
    .MCYCLE_END(mcyc), .BUS_GRANTED(grant), .SLEEP(sleep),
    .WAIT_STATE(wait_st), .REF_BUSY(ref_busy), .REF_STROBE_N(ref_strobe_n),
    .REF_WAIT(ref_wait), .REF_ADDR(ref_addr));
dram_model ram (.strobe_n(ref_strobe_n), .row(ref_addr),
    .rows_done(rows_done), .row_errs(row_errs));
initial begin
    forever #25 clk = ~clk;
end
always @(posedge clk) cyc <= cyc + 1;
always @(negedge clk) prev_busy <= ref_busy;
task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
        mismatches++;
        $display("BAD %s expected %h seen %h", what, exp, got);
    end
endtask
task automatic io_write(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
endtask
task automatic io_read(logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    @(negedge clk);
    d = io_rdata;
endtask
task automatic next_rise(output int n);
    n = 0;
    do begin
        @(negedge clk);
        n++;
    end while (!(ref_busy === 1'b1 && prev_busy === 1'b0) && n < 200);
endtask
task automatic busy_len(output int n);
    n = 1;
    @(negedge clk);
    while (ref_busy === 1'b1 && n < 9) begin
        n++;
        @(negedge clk);
    end
endtask
task automatic t_reset;
    logic [7:0] d;
    int n;
    io_read(`RC_ADDR_REFRESH_CONTROL, d);
    check("reset value", 8'hC0, d);
    io_read(8'h37, d);
    check("unmapped read", 8'h00, d);
    io_write(8'h37, 8'h00);
    io_read(`RC_ADDR_REFRESH_CONTROL, d);
    check("unmapped write", 8'hC0, d);
    next_rise(n);
    next_rise(n);
    check("reset interval", 8'h0A, 8'(n));
    busy_len(n);
    check("reset length", 8'h03, 8'(n));
endtask
task automatic t_intervals;
    logic [7:0] gap[4] = '{8'h0A, 8'h14, 8'h28, 8'h50};
    int n;
    for (int s = 0; s < 4; s++) begin
        io_write(`RC_ADDR_REFRESH_CONTROL, 8'h80 | 8'(s));
        next_rise(n);
        next_rise(n);
        check("interval", gap[s], 8'(n));
        busy_len(n);
        check("short length", 8'h02, 8'(n));
    end
endtask
task automatic t_grant;
    int n;
    int t0;
    io_write(`RC_ADDR_REFRESH_CONTROL, 8'hC0);
    next_rise(n);
    next_rise(n);
    t0 = cyc;
    @(posedge clk);
    grant <= 1'b1;
    repeat (93) @(posedge clk);
    grant <= 1'b0;
    next_rise(n);
    check("grant gap", 8'h64, 8'(cyc - t0));
    t0 = rows_done;
    @(posedge clk);
    wait_st <= 1'b1;
    repeat (30) @(posedge clk);
    wait_st <= 1'b0;
    check("wait rows", 8'(t0), 8'(rows_done));
endtask
task automatic t_sleep;
    int n;
    int t0;
    int r0;
    // the rise after the wait test is off the timer grid
    next_rise(n);
    next_rise(n);
    t0 = cyc;
    r0 = rows_done;
    @(posedge clk);
    sleep <= 1'b1;
    repeat (48) @(posedge clk);
    sleep <= 1'b0;
    mcyc <= 1'b0;
    repeat (3) @(negedge clk);
    check("sleep rows", 8'(r0), 8'(rows_done));
    check("early busy", 8'h00, {7'h00, ref_busy});
    @(posedge clk);
    mcyc <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check("exit refresh", 8'h01, {7'h00, ref_busy});
    next_rise(n);
    check("timer phase", 8'h00, 8'((cyc - t0) % 10));
endtask
task automatic t_off;
    int n;
    io_write(`RC_ADDR_REFRESH_CONTROL, 8'h00);
    next_rise(n);
    check("disabled gap", 8'hC8, 8'(n));
    check("row steps", 8'h00, 8'(row_errs));
    check("address count", 8'(rows_done), ref_addr);
endtask
task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
        $display("All checks passed");
    end else begin
        $display("Checks failed");
    end
    $finish;
endtask
initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    report_and_stop;
end
initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_intervals;
    t_grant;
    t_sleep;
    t_off;
    report_and_stop;
end
endmodule
